/* File: dvcr_pkg.sv */
// dvcr_pkg: constants, register map and carrier types for the divider / calibration-start / ramp-threshold registers
package dvcr_pkg;

   // ------------------------------------------------------------
   // bus geometry and responses
   // ------------------------------------------------------------
   localparam int unsigned DVCR_ADDR_W = 12;
   localparam int unsigned DVCR_IDX_W = 10;
   localparam logic [1:0] DVCR_RESP_OKAY = 2'h0;
   localparam logic [1:0] DVCR_RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------
   // register indices (byte address = index * 4)
   // ------------------------------------------------------------
   localparam logic [9:0] DVCR_IDX_CTRL = 10'h000;
   localparam logic [9:0] DVCR_IDX_STATUS = 10'h001;
   localparam logic [9:0] DVCR_IDX_OUT_DIV = 10'h04b;
   localparam logic [9:0] DVCR_IDX_FIXED_A = 10'h04c;
   localparam logic [9:0] DVCR_IDX_FIXED_B = 10'h04d;
   localparam logic [9:0] DVCR_IDX_CAL_START = 10'h04e;
   localparam logic [9:0] DVCR_IDX_THR_UPPER = 10'h04f;
   localparam logic [9:0] DVCR_IDX_THR_LOWER = 10'h050;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [15:0] DVCR_RST_OUT_DIV = 16'h0800;
   localparam logic [15:0] DVCR_RST_FIXED_A = 16'h000c;
   localparam logic [15:0] DVCR_RST_FIXED_B = 16'h0000;
   localparam logic [15:0] DVCR_RST_CAL_START = 16'h0064;
   localparam logic [15:0] DVCR_RST_THR_UPPER = 16'h0000;
   localparam logic [15:0] DVCR_RST_THR_LOWER = 16'h0000;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int unsigned DVCR_DIV_SEL_LSB = 6;
   localparam int unsigned DVCR_DIV_SEL_MSB = 10;
   localparam int unsigned DVCR_THR_TOP_BIT = 11;
   localparam int unsigned DVCR_RECAL_CUR_BIT = 9;
   localparam int unsigned DVCR_CAP_LSB = 1;
   localparam int unsigned DVCR_CAP_MSB = 8;
   localparam int unsigned DVCR_CTRL_SOFT_RST_BIT = 0;
   localparam logic [7:0] DVCR_CAP_MAX = 8'hb7;

   // ------------------------------------------------------------
   // divide select codes and ratios
   // ------------------------------------------------------------
   localparam logic [4:0] DVCR_DIV_CODE_2 = 5'h00;
   localparam logic [4:0] DVCR_DIV_CODE_4 = 5'h01;
   localparam logic [4:0] DVCR_DIV_CODE_8 = 5'h03;
   localparam logic [4:0] DVCR_DIV_CODE_16 = 5'h05;
   localparam logic [4:0] DVCR_DIV_CODE_32 = 5'h07;
   localparam logic [4:0] DVCR_DIV_CODE_64 = 5'h09;
   localparam logic [4:0] DVCR_DIV_CODE_128 = 5'h0c;
   localparam logic [4:0] DVCR_DIV_CODE_256 = 5'h0e;

   // ------------------------------------------------------------
   // carrier types
   // ------------------------------------------------------------
   localparam int unsigned DVCR_CORE_W = 3;
   localparam int unsigned DVCR_BIAS_W = 9;

   typedef struct packed {
      logic [DVCR_CORE_W-1:0] core_select;
      logic [7:0] cap_start;
      logic [DVCR_BIAS_W-1:0] bias_start;
   } dvcr_cal_seed_t;

   typedef struct packed {
      logic [15:0] output_divider_config;
      logic [15:0] fixed_config_word_a;
      logic [15:0] fixed_config_word_b;
      logic [15:0] calibration_start_config;
      logic [15:0] ramp_threshold_upper;
      logic [15:0] ramp_threshold_lower;
   } dvcr_regs_t;

endpackage

/* File: dvcr_div_decode.sv */
// dvcr_div_decode: maps the output divide select code onto its divide ratio
`timescale 1ns/1ps
module dvcr_div_decode
   import dvcr_pkg::*;
(
   input wire logic [4:0] i_code,
   output logic [8:0] o_ratio,
   output logic o_valid
);

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   always_comb begin
      o_valid = 1'b1;
      case (i_code)
         DVCR_DIV_CODE_2: o_ratio = 9'h002;
         DVCR_DIV_CODE_4: o_ratio = 9'h004;
         DVCR_DIV_CODE_8: o_ratio = 9'h008;
         DVCR_DIV_CODE_16: o_ratio = 9'h010;
         DVCR_DIV_CODE_32: o_ratio = 9'h020;
         DVCR_DIV_CODE_64: o_ratio = 9'h040;
         DVCR_DIV_CODE_128: o_ratio = 9'h080;
         DVCR_DIV_CODE_256: o_ratio = 9'h100;
         default: begin
            // unused codes give ratio zero so the divider can hold off
            o_ratio = 9'h000;
            o_valid = 1'b0;
         end
      endcase
   end

endmodule // dvcr_div_decode

/* File: dvcr_seed_sel.sv */
// dvcr_seed_sel: picks the calibration starting point, programmed or currently active
`timescale 1ns/1ps
module dvcr_seed_sel
   import dvcr_pkg::*;
(
   input wire logic i_use_current,
   input wire dvcr_cal_seed_t i_programmed,
   input wire dvcr_cal_seed_t i_active,
   output dvcr_cal_seed_t o_seed
);

   // ------------------------------------------------------------
   // select
   // ------------------------------------------------------------
   always_comb begin
      // starting from the active values skips the coarse search, quick for small hops
      o_seed = i_use_current ? i_active : i_programmed;
   end

endmodule // dvcr_seed_sel

/* File: dvcr_regs.sv */
// dvcr_regs: AXI4-Lite register slice for output divider, calibration start and ramp threshold
//
// How it works
// - divide codes 0,1,3,5,7,9,12,14 give 2..256
// - soft reset restores both fixed words
// - threshold is start bit 11, upper, lower
// - threshold bounds oscillator change before recalibration
// - recalibration starts programmed or from active values
// - cap start code seeds calibration, reset 32h
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
module dvcr_regs
   import dvcr_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [DVCR_ADDR_W-1:0] i_s_axi_awaddr,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   output logic [1:0] o_s_axi_bresp,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   input wire logic [DVCR_ADDR_W-1:0] i_s_axi_araddr,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   input wire logic [DVCR_CORE_W-1:0] i_prog_core_select,
   input wire logic [DVCR_BIAS_W-1:0] i_prog_bias_start,
   input wire dvcr_cal_seed_t i_active_seed,
   output logic [8:0] o_divide_ratio,
   output logic o_divide_code_valid,
   output logic [15:0] o_fixed_config_word_a,
   output logic [15:0] o_fixed_config_word_b,
   output logic [32:0] o_ramp_recal_threshold,
   output logic o_recal_from_current_enable,
   output dvcr_cal_seed_t o_cal_seed
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic aw_have;
      logic w_have;
      logic [DVCR_IDX_W-1:0] aw_idx;
      logic [15:0] wdata;
      logic [1:0] wstrb;
      dvcr_regs_t regs;
      logic [8:0] ratio;
      logic ratio_ok;
      logic [32:0] thresh;
      logic recal_cur;
      dvcr_cal_seed_t seed;
   } dvcr_state_t;

   localparam dvcr_regs_t DVCR_REGS_RST = '{
      output_divider_config: DVCR_RST_OUT_DIV,
      fixed_config_word_a: DVCR_RST_FIXED_A,
      fixed_config_word_b: DVCR_RST_FIXED_B,
      calibration_start_config: DVCR_RST_CAL_START,
      ramp_threshold_upper: DVCR_RST_THR_UPPER,
      ramp_threshold_lower: DVCR_RST_THR_LOWER
   };

   localparam dvcr_state_t DVCR_STATE_RST = '{
      awready: 1'b1,
      wready: 1'b1,
      bvalid: 1'b0,
      bresp: DVCR_RESP_OKAY,
      arready: 1'b1,
      rvalid: 1'b0,
      rresp: DVCR_RESP_OKAY,
      rdata: 32'h0000_0000,
      aw_have: 1'b0,
      w_have: 1'b0,
      aw_idx: DVCR_IDX_CTRL,
      wdata: 16'h0000,
      wstrb: 2'h0,
      regs: DVCR_REGS_RST,
      ratio: 9'h002,
      ratio_ok: 1'b1,
      thresh: 33'h0_0000_0000,
      recal_cur: 1'b0,
      seed: '0
   };

   dvcr_state_t s_reg;
   dvcr_state_t s_next;

   logic [8:0] dec_ratio;
   logic dec_ok;
   dvcr_cal_seed_t prog_seed;
   dvcr_cal_seed_t sel_seed;
   logic wr_fire;
   logic soft_hit;
   logic cap_in_range;
   logic [DVCR_IDX_W-1:0] rd_idx;

   function automatic logic [15:0] merge_lanes(input logic [15:0] old, input logic [15:0] data,
                                               input logic [1:0] strb);
      return {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
   endfunction

   // ------------------------------------------------------------
   // decode and seed selection
   // ------------------------------------------------------------
   dvcr_div_decode u_div_decode (
      .i_code(s_reg.regs.output_divider_config[DVCR_DIV_SEL_MSB:DVCR_DIV_SEL_LSB]),
      .o_ratio(dec_ratio),
      .o_valid(dec_ok)
   );

   assign prog_seed = '{
      core_select: i_prog_core_select,
      cap_start: s_reg.regs.calibration_start_config[DVCR_CAP_MSB:DVCR_CAP_LSB],
      bias_start: i_prog_bias_start
   };

   dvcr_seed_sel u_seed_sel (
      .i_use_current(s_reg.regs.calibration_start_config[DVCR_RECAL_CUR_BIT]),
      .i_programmed(prog_seed),
      .i_active(i_active_seed),
      .o_seed(sel_seed)
   );

   assign wr_fire = s_reg.aw_have && s_reg.w_have && !s_reg.bvalid;
   assign soft_hit = wr_fire && (s_reg.aw_idx == DVCR_IDX_CTRL) && s_reg.wstrb[0]
                     && s_reg.wdata[DVCR_CTRL_SOFT_RST_BIT];
   assign cap_in_range = s_reg.regs.calibration_start_config[DVCR_CAP_MSB:DVCR_CAP_LSB] <= DVCR_CAP_MAX;
   assign rd_idx = i_s_axi_araddr[DVCR_ADDR_W-1:2];

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      // write address and data are taken independently, each held until the response
      if (i_s_axi_awvalid && s_reg.awready) begin
         s_next.aw_have = 1'b1;
         s_next.aw_idx = i_s_axi_awaddr[DVCR_ADDR_W-1:2];
         s_next.awready = 1'b0;
      end
      if (i_s_axi_wvalid && s_reg.wready) begin
         s_next.w_have = 1'b1;
         s_next.wdata = i_s_axi_wdata[15:0];
         s_next.wstrb = i_s_axi_wstrb[1:0];
         s_next.wready = 1'b0;
      end
      if (s_reg.bvalid && i_s_axi_bready) begin
         s_next.bvalid = 1'b0;
         s_next.awready = 1'b1;
         s_next.wready = 1'b1;
      end
      if (wr_fire) begin
         s_next.aw_have = 1'b0;
         s_next.w_have = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = DVCR_RESP_OKAY;
         case (s_reg.aw_idx)
            DVCR_IDX_CTRL: begin
               if (soft_hit) begin
                  s_next.regs = DVCR_REGS_RST;
               end
            end
            DVCR_IDX_OUT_DIV: begin
               s_next.regs.output_divider_config =
                  merge_lanes(s_reg.regs.output_divider_config, s_reg.wdata, s_reg.wstrb);
            end
            DVCR_IDX_FIXED_A: begin
               s_next.regs.fixed_config_word_a =
                  merge_lanes(s_reg.regs.fixed_config_word_a, s_reg.wdata, s_reg.wstrb);
            end
            DVCR_IDX_FIXED_B: begin
               s_next.regs.fixed_config_word_b =
                  merge_lanes(s_reg.regs.fixed_config_word_b, s_reg.wdata, s_reg.wstrb);
            end
            DVCR_IDX_CAL_START: begin
               s_next.regs.calibration_start_config =
                  merge_lanes(s_reg.regs.calibration_start_config, s_reg.wdata, s_reg.wstrb);
            end
            DVCR_IDX_THR_UPPER: begin
               s_next.regs.ramp_threshold_upper =
                  merge_lanes(s_reg.regs.ramp_threshold_upper, s_reg.wdata, s_reg.wstrb);
            end
            DVCR_IDX_THR_LOWER: begin
               s_next.regs.ramp_threshold_lower =
                  merge_lanes(s_reg.regs.ramp_threshold_lower, s_reg.wdata, s_reg.wstrb);
            end
            default: begin
               // status is read-only; it and unmapped words refuse the write
               s_next.bresp = DVCR_RESP_SLVERR;
            end
         endcase
      end
      if (s_reg.rvalid && i_s_axi_rready) begin
         s_next.rvalid = 1'b0;
         s_next.arready = 1'b1;
      end
      if (i_s_axi_arvalid && s_reg.arready) begin
         s_next.arready = 1'b0;
         s_next.rvalid = 1'b1;
         s_next.rresp = DVCR_RESP_OKAY;
         case (rd_idx)
            DVCR_IDX_CTRL: s_next.rdata = 32'h0000_0000;
            DVCR_IDX_STATUS: s_next.rdata = {20'h0_0000, s_reg.recal_cur, cap_in_range, s_reg.ratio_ok, s_reg.ratio};
            DVCR_IDX_OUT_DIV: s_next.rdata = {16'h0000, s_reg.regs.output_divider_config};
            DVCR_IDX_FIXED_A: s_next.rdata = {16'h0000, s_reg.regs.fixed_config_word_a};
            DVCR_IDX_FIXED_B: s_next.rdata = {16'h0000, s_reg.regs.fixed_config_word_b};
            DVCR_IDX_CAL_START: s_next.rdata = {16'h0000, s_reg.regs.calibration_start_config};
            DVCR_IDX_THR_UPPER: s_next.rdata = {16'h0000, s_reg.regs.ramp_threshold_upper};
            DVCR_IDX_THR_LOWER: s_next.rdata = {16'h0000, s_reg.regs.ramp_threshold_lower};
            default: begin
               s_next.rdata = 32'h0000_0000;
               s_next.rresp = DVCR_RESP_SLVERR;
            end
         endcase
      end
      // derived outputs follow the stored words one cycle later
      s_next.ratio = dec_ratio;
      s_next.ratio_ok = dec_ok;
      s_next.thresh = {s_reg.regs.calibration_start_config[DVCR_THR_TOP_BIT],
                       s_reg.regs.ramp_threshold_upper, s_reg.regs.ramp_threshold_lower};
      s_next.recal_cur = s_reg.regs.calibration_start_config[DVCR_RECAL_CUR_BIT];
      s_next.seed = sel_seed;
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_reg <= DVCR_STATE_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign o_s_axi_awready = s_reg.awready;
   assign o_s_axi_wready = s_reg.wready;
   assign o_s_axi_bvalid = s_reg.bvalid;
   assign o_s_axi_bresp = s_reg.bresp;
   assign o_s_axi_arready = s_reg.arready;
   assign o_s_axi_rvalid = s_reg.rvalid;
   assign o_s_axi_rdata = s_reg.rdata;
   assign o_s_axi_rresp = s_reg.rresp;
   assign o_divide_ratio = s_reg.ratio;
   assign o_divide_code_valid = s_reg.ratio_ok;
   assign o_fixed_config_word_a = s_reg.regs.fixed_config_word_a;
   assign o_fixed_config_word_b = s_reg.regs.fixed_config_word_b;
   assign o_ramp_recal_threshold = s_reg.thresh;
   assign o_recal_from_current_enable = s_reg.recal_cur;
   assign o_cal_seed = s_reg.seed;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   div_ratio_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (s_reg.regs.output_divider_config[DVCR_DIV_SEL_MSB:DVCR_DIV_SEL_LSB] == 5'h0c)
      |=> (o_divide_ratio == 9'h080) && o_divide_code_valid)
      else $error("divide code 12 did not give ratio 128");

   div_unused_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (s_reg.regs.output_divider_config[DVCR_DIV_SEL_MSB:DVCR_DIV_SEL_LSB] == 5'h02)
      |=> !o_divide_code_valid && (o_divide_ratio == 9'h000))
      else $error("unused divide code flagged as valid");

   soft_fixed_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      soft_hit |=> (o_fixed_config_word_a == 16'h000c) && (o_fixed_config_word_b == 16'h0000))
      else $error("fixed words not restored by soft reset");

   soft_cap_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      soft_hit |=> (s_reg.regs.calibration_start_config == 16'h0064) ##1 (o_cal_seed.cap_start == 8'h32
      || o_recal_from_current_enable))
      else $error("cap start code not back at reset value");

   thresh_join_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      1'b1 |=> o_ramp_recal_threshold == {$past(s_reg.regs.calibration_start_config[DVCR_THR_TOP_BIT]),
      $past(s_reg.regs.ramp_threshold_upper), $past(s_reg.regs.ramp_threshold_lower)})
      else $error("ramp threshold assembled wrongly");

   // the edge that releases reset still loads the reset seed, so no attempt starts there
   seed_prog_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_rst_n && !s_reg.regs.calibration_start_config[DVCR_RECAL_CUR_BIT]
      |=> o_cal_seed == $past(prog_seed))
      else $error("calibration did not start from programmed values");

   seed_active_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      s_reg.regs.calibration_start_config[DVCR_RECAL_CUR_BIT]
      |=> (o_cal_seed == $past(i_active_seed)) && o_recal_from_current_enable)
      else $error("calibration did not start from active values");

   upper_write_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (wr_fire && (s_reg.aw_idx == DVCR_IDX_THR_UPPER) && (s_reg.wstrb == 2'h3))
      |=> (s_reg.regs.ramp_threshold_upper == $past(s_reg.wdata)) && o_s_axi_bvalid)
      else $error("threshold upper word did not take the write");

   write_resp_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (o_s_axi_bvalid && !i_s_axi_bready) |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
      else $error("write response dropped before it was taken");

endmodule // dvcr_regs

/* File: dvcr_regs_tb.sv */
// dvcr_regs_tb: self-checking bench for the divider, calibration-start and ramp-threshold register slice
`timescale 1ns/1ps
module dvcr_regs_tb
   import dvcr_pkg::*;
;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic i_mclk, i_rst_n;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [DVCR_ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [DVCR_CORE_W-1:0] prog_core;
   logic [DVCR_BIAS_W-1:0] prog_bias;
   dvcr_cal_seed_t active_seed, cal_seed;
   logic [8:0] ratio;
   logic code_valid, recal_cur;
   logic [15:0] fixed_a, fixed_b;
   logic [32:0] thresh;
   int err_total, n_checks;

   dvcr_regs dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
      .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr),
      .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb),
      .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .o_s_axi_bresp(bresp),
      .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .i_s_axi_araddr(araddr),
      .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
      .i_prog_core_select(prog_core), .i_prog_bias_start(prog_bias), .i_active_seed(active_seed),
      .o_divide_ratio(ratio), .o_divide_code_valid(code_valid), .o_fixed_config_word_a(fixed_a),
      .o_fixed_config_word_b(fixed_b), .o_ramp_recal_threshold(thresh),
      .o_recal_from_current_enable(recal_cur), .o_cal_seed(cal_seed));

   initial begin
      i_mclk = 1'b0;
      forever #12.5 i_mclk = ~i_mclk;
   end

   // ------------------------------------------------------------
   // report and compare tasks
   // ------------------------------------------------------------
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk_val(input logic [32:0] got, input logic [32:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected response at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic hang();
      err_total++;
      $display("unexpected hang at %0t: got %h exp %h", $time, 1'b0, 1'b1);
      close_out();
   endtask

   // ------------------------------------------------------------
   // bus tasks: valid and payload held until their own ready edge
   // ------------------------------------------------------------
   task automatic axi_wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s, output logic [1:0] r);
      int n;
      logic done;
      done = 1'b0;
      @(posedge i_mclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= {16'h0000, d};
      wstrb <= s;
      bready <= 1'b1;
      for (n = 0; n < 50 && !done; n++) begin
         @(posedge i_mclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            r = bresp;
            bready <= 1'b0;
            done = 1'b1;
         end
      end
      if (!done) hang();
   endtask

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      logic done;
      done = 1'b0;
      @(posedge i_mclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      for (n = 0; n < 50 && !done; n++) begin
         @(posedge i_mclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            done = 1'b1;
         end
      end
      if (!done) hang();
   endtask

   // derived outputs lag the stored word by one edge
   task automatic settle();
      repeat (2) @(posedge i_mclk);
      #1;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      chk_val({1'b0, d}, {1'b0, exp});
      chk_resp(r, er);
   endtask

   // ------------------------------------------------------------
   // divide select rows: code, ratio, valid
   // ------------------------------------------------------------
   typedef struct packed {
      logic [4:0] code;
      logic [8:0] ratio;
      logic valid;
   } dvcr_row_t;

   localparam dvcr_row_t ROWS [10] = '{
      '{5'h00, 9'h002, 1'b1}, '{5'h01, 9'h004, 1'b1}, '{5'h03, 9'h008, 1'b1}, '{5'h05, 9'h010, 1'b1},
      '{5'h07, 9'h020, 1'b1}, '{5'h09, 9'h040, 1'b1}, '{5'h0c, 9'h080, 1'b1}, '{5'h0e, 9'h100, 1'b1},
      '{5'h02, 9'h000, 1'b0}, '{5'h1f, 9'h000, 1'b0}};

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      logic [1:0] r;
      logic [15:0] dv;
      err_total = 0;
      n_checks = 0;
      i_rst_n = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 12'h000;
      araddr = 12'h000;
      wdata = 32'h0000_0000;
      wstrb = 4'h0;
      prog_core = 3'h5;
      prog_bias = 9'h1a3;
      active_seed = '{3'h2, 8'h77, 9'h0c5};
      repeat (20) @(posedge i_mclk);
      chk_val({17'h0_0000, fixed_a}, 33'h0_0000_000c);
      i_rst_n <= 1'b1;
      settle();
      chk_val({25'h00_0000, cal_seed.cap_start}, 33'h0_0000_0032);
      rd_chk(12'h12c, 32'h0000_0800, DVCR_RESP_OKAY);
      rd_chk(12'h130, 32'h0000_000c, DVCR_RESP_OKAY);
      rd_chk(12'h134, 32'h0000_0000, DVCR_RESP_OKAY);
      rd_chk(12'h138, 32'h0000_0064, DVCR_RESP_OKAY);
      rd_chk(12'h13c, 32'h0000_0000, DVCR_RESP_OKAY);
      rd_chk(12'h140, 32'h0000_0000, DVCR_RESP_OKAY);
      rd_chk(12'h004, 32'h0000_0602, DVCR_RESP_OKAY);
      rd_chk(12'h000, 32'h0000_0000, DVCR_RESP_OKAY);
      $display("test reset values done");
      foreach (ROWS[i]) begin
         dv = 16'h0800 | (16'(ROWS[i].code) << 6);
         axi_wr(12'h12c, dv, 4'h3, r);
         settle();
         chk_val({24'h00_0000, ratio}, {24'h00_0000, ROWS[i].ratio});
         chk_val({32'h0000_0000, code_valid}, {32'h0000_0000, ROWS[i].valid});
         rd_chk(12'h12c, {16'h0000, dv}, DVCR_RESP_OKAY);
      end
      $display("test divide select done");
      // threshold top bit lives in the calibration word, apart from the two halves
      axi_wr(12'h138, 16'h08b5, 4'h3, r);
      axi_wr(12'h13c, 16'hbeef, 4'h3, r);
      axi_wr(12'h140, 16'h1234, 4'h3, r);
      settle();
      chk_val(thresh, 33'h1_beef_1234);
      chk_val({32'h0000_0000, recal_cur}, 33'h0_0000_0000);
      chk_val({13'h0000, cal_seed}, {13'h0000, 3'h5, 8'h5a, 9'h1a3});
      axi_wr(12'h138, 16'h0ab5, 4'h3, r);
      settle();
      chk_val({32'h0000_0000, recal_cur}, 33'h0_0000_0001);
      chk_val({13'h0000, cal_seed}, {13'h0000, 3'h2, 8'h77, 9'h0c5});
      @(posedge i_mclk);
      active_seed <= '{3'h6, 8'h11, 9'h022};
      settle();
      chk_val({13'h0000, cal_seed}, {13'h0000, 3'h6, 8'h11, 9'h022});
      axi_wr(12'h140, 16'hffff, 4'h1, r);
      settle();
      chk_val(thresh, 33'h1_beef_12ff);
      $display("test threshold and seed done");
      axi_wr(12'h130, 16'h5555, 4'h3, r);
      axi_wr(12'h134, 16'haaaa, 4'h3, r);
      settle();
      chk_val({17'h0_0000, fixed_b}, 33'h0_0000_aaaa);
      axi_wr(12'h000, 16'h0001, 4'h1, r);
      settle();
      chk_val({17'h0_0000, fixed_a}, 33'h0_0000_000c);
      chk_val({17'h0_0000, fixed_b}, 33'h0_0000_0000);
      chk_val(thresh, 33'h0_0000_0000);
      rd_chk(12'h138, 32'h0000_0064, DVCR_RESP_OKAY);
      rd_chk(12'h12c, 32'h0000_0800, DVCR_RESP_OKAY);
      $display("test soft reset done");
      axi_wr(12'h200, 16'h1234, 4'h3, r);
      chk_resp(r, DVCR_RESP_SLVERR);
      rd_chk(12'h200, 32'h0000_0000, DVCR_RESP_SLVERR);
      axi_wr(12'h004, 16'hffff, 4'h3, r);
      chk_resp(r, DVCR_RESP_SLVERR);
      $display("test refused access done");
      axi_wr(12'h130, 16'h0f0f, 4'h3, r);
      @(posedge i_mclk);
      i_rst_n <= 1'b0;
      repeat (3) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      settle();
      chk_val({17'h0_0000, fixed_a}, 33'h0_0000_000c);
      rd_chk(12'h130, 32'h0000_000c, DVCR_RESP_OKAY);
      axi_wr(12'h130, 16'h000c, 4'h3, r);
      chk_resp(r, DVCR_RESP_OKAY);
      axi_wr(12'h134, 16'h0000, 4'h3, r);
      rd_chk(12'h134, 32'h0000_0000, DVCR_RESP_OKAY);
      $display("test second reset done");
      close_out();
   end
endmodule // dvcr_regs_tb
